// ==== rtl/schf_pkg.sv ====
// Purpose: shared constants for the stepper current, hold and fault block
// Assumes: 100 MHz hclk, 32-bit AHB-Lite register words
// Notes:   offsets are byte addresses, one aligned word per register
package schf_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_CURRENT_SETTING_REG    = 8'h04;
  localparam logic [7:0] ADDR_STEP    = 8'h08;
  localparam logic [7:0] ADDR_FAULT   = 8'h0c;
  localparam logic [7:0] ADDR_OCDET   = 8'h10;
  localparam logic [7:0] ADDR_IRQMASK = 8'h14;
  localparam logic [7:0] ADDR_DAC     = 8'h18;
  localparam logic [7:0] ADDR_STALLC  = 8'h1c;

  // reset values
  localparam logic [5:0] RUN_CODE_RST  = 6'h09;
  localparam logic [5:0] HOLD_CODE_RST = 6'h00;
  localparam logic [2:0] HOLD_DLY_RST  = 3'h0;

  // field positions
  localparam int CTRL_STEP_BIT   = 0;  // write-one step strobe
  localparam int CTRL_DLY_LSB    = 4;  // hold delay code [6:4]
  localparam int CURRENT_SETTING_REG_HOLD_LSB   = 8;  // hold code [13:8]
  localparam int FLT_OC_BIT      = 0;
  localparam int FLT_OV_BIT      = 1;
  localparam int FLT_HOLD_BIT    = 4;  // read-only: hold active
  localparam int FLT_BR_BIT      = 5;  // read-only: bridges enabled

  // current step of 125 mA in mA; code 0 is one step
  localparam int CURRENT_STEP_MA = 125;

  // hold delay base 15.6 ms, doubled per code above one
  localparam real HOLD_BASE_MS   = 15.6;
  localparam real CLK_PERIOD_NS  = 10.0;
  localparam int  HOLD_BASE_CYC  = int'(HOLD_BASE_MS * 1.0e6 / CLK_PERIOD_NS);
endpackage

// ==== rtl/schf_core.sv ====
// Purpose: winding current select, automatic hold and fault latching
// Assumes: synchronous inputs; AHB-Lite single word transfers
// Notes:   step table percentage is supplied by the indexer via ports
//
// The implementer's own choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ns
module schf_core
  import schf_pkg::*;
#(
  parameter int HOLD_BASE   = HOLD_BASE_CYC,
  parameter int OC_DEGLITCH = 8,
  parameter int PCT_W       = 8
) (
  // clock and reset
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               clk_en,
  // ahb-lite slave
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic               hready,
  input  wire logic [31:0]        hwdata,
  output logic      [31:0]        hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  // step and sensing
  input  wire logic               step_pin,
  input  wire logic [PCT_W-1:0]   pct_a,
  input  wire logic [PCT_W-1:0]   pct_b,
  input  wire logic [3:0]         oc_raw,
  input  wire logic               ov_raw,
  // outputs
  output logic      [PCT_W+11:0]  dac_a,
  output logic      [PCT_W+11:0]  dac_b,
  output logic                    bridge_en,
  output logic                    stall_clr,
  output logic                    irq,
  output logic                    error_pin_low_active_o,
  output logic                    error_pin_low_active_oe
);

  // peak current in mA for codes 0 to 31; six-bit codes above 31 wrap at twelve bits
  function automatic logic [11:0] peak_ma(input logic [5:0] code);
    peak_ma = 12'((code + 7'd1) * CURRENT_STEP_MA);
  endfunction

  // hold delay in cycles; zero means disabled
  function automatic logic [31:0] hold_cycles(input logic [2:0] code);
    hold_cycles = (code == 3'h0) ? 32'h0 : 32'(HOLD_BASE) << (code - 3'h1);
  endfunction

  // state
  logic [5:0]       run_peak_code_q, run_peak_code_d;
  logic [5:0]       hold_peak_code_q, hold_peak_code_d;
  logic [2:0]       hold_delay_code_q, hold_delay_code_d;
  logic             hold_q, hold_d;
  logic [31:0]      hcnt_q, hcnt_d;
  logic             step_pin_q;
  logic [3:0]       ocflag_q, ocflag_d;
  logic             ovflag_q, ovflag_d;
  logic [3:0]       irqmask_q, irqmask_d;
  logic [3:0]       ocglit_q [4];
  logic [3:0]       ocglit_d [4];
  logic             aw_q, aw_d, ar_q, ar_d;
  logic [7:0]       aaddr_q, aaddr_d;
  logic [31:0]      rdata_d;
  logic [PCT_W+11:0] dac_a_d, dac_b_d;
  logic             stall_clr_d, irq_d, flt_d, br_d;
  logic             step_ev, reg_step;
  logic [3:0]       sticky;

  // address phase capture
  wire        addr_ok = hsel && hready && htrans[1];
  wire        wr_data = aw_q;

  always_comb begin
    aw_d    = addr_ok && hwrite;
    ar_d    = addr_ok && !hwrite;
    aaddr_d = addr_ok ? haddr[7:0] : aaddr_q;
  end

  // step events from pin edge or register strobe
  always_comb begin
    reg_step = wr_data && aaddr_q == ADDR_CTRL && hwdata[CTRL_STEP_BIT];
    step_ev  = (step_pin && !step_pin_q) || reg_step;
  end

  // configuration registers
  always_comb begin
    run_peak_code_d   = run_peak_code_q;
    hold_peak_code_d  = hold_peak_code_q;
    hold_delay_code_d = hold_delay_code_q;
    irqmask_d         = irqmask_q;
    if (wr_data && aaddr_q == ADDR_CURRENT_SETTING_REG) begin
      run_peak_code_d  = hwdata[5:0];
      hold_peak_code_d = hwdata[CURRENT_SETTING_REG_HOLD_LSB +: 6];
    end
    if (wr_data && aaddr_q == ADDR_CTRL)
      hold_delay_code_d = hwdata[CTRL_DLY_LSB +: 3];
    if (wr_data && aaddr_q == ADDR_IRQMASK)
      irqmask_d = hwdata[3:0];
  end

  // hold timer: restarts on every step and while disabled
  always_comb begin
    hold_d      = hold_q;
    hcnt_d      = hcnt_q;
    stall_clr_d = 1'b0;
    if (step_ev || hold_delay_code_q == 3'h0) begin
      hcnt_d = 32'h0;
      hold_d = 1'b0;
    end else if (!hold_q) begin
      if (hcnt_q + 32'h1 >= hold_cycles(hold_delay_code_q)) begin
        hold_d      = 1'b1;
        stall_clr_d = 1'b1;
      end else begin
        hcnt_d = hcnt_q + 32'h1;
      end
    end
  end

  // phase targets; hold_d used so a step restores run current at once
  always_comb begin
    logic [11:0] pk;
    pk      = hold_d ? peak_ma(hold_peak_code_q) : peak_ma(run_peak_code_q);
    // widen both factors first: a self-sized product would wrap at twelve bits
    dac_a_d = (PCT_W+12)'(pct_a) * (PCT_W+12)'(pk);
    dac_b_d = (PCT_W+12)'(pct_b) * (PCT_W+12)'(pk);
  end

  // over-current deglitch, per transistor
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      ocglit_d[i] = oc_raw[i] ? ((ocglit_q[i] == 4'(OC_DEGLITCH)) ? ocglit_q[i] : ocglit_q[i] + 4'h1) : 4'h0;
    end
  end

  // fault flags: set wins over write-one clear
  always_comb begin
    ocflag_d = ocflag_q;
    ovflag_d = ovflag_q;
    if (wr_data && aaddr_q == ADDR_OCDET)
      ocflag_d = ocflag_q & ~hwdata[3:0];
    if (wr_data && aaddr_q == ADDR_FAULT && hwdata[FLT_OV_BIT])
      ovflag_d = 1'b0;
    for (int i = 0; i < 4; i++)
      if (ocglit_q[i] == 4'(OC_DEGLITCH))
        ocflag_d[i] = 1'b1;
    if (ov_raw)
      ovflag_d = 1'b1;
    sticky = {2'b00, ovflag_d, |ocflag_d};
    flt_d  = |ocflag_d || ovflag_d;
    br_d   = !(|ocflag_d) && !ov_raw;
    irq_d  = |(sticky & irqmask_d);
  end

  // read mux, registered at the address edge so data stands in the data phase
  always_comb begin
    rdata_d = 32'h0;
    if (addr_ok && !hwrite) begin
      unique case (haddr[7:0])
        ADDR_CTRL:    rdata_d[CTRL_DLY_LSB +: 3] = hold_delay_code_q;
        ADDR_CURRENT_SETTING_REG:    rdata_d = {18'h0, hold_peak_code_q, 2'b00, run_peak_code_q};
        ADDR_FAULT: begin
          rdata_d[FLT_OC_BIT]   = |ocflag_q;
          rdata_d[FLT_OV_BIT]   = ovflag_q;
          rdata_d[FLT_HOLD_BIT] = hold_q;
          rdata_d[FLT_BR_BIT]   = bridge_en;
        end
        ADDR_OCDET:   rdata_d[3:0] = ocflag_q;
        ADDR_IRQMASK: rdata_d[3:0] = irqmask_q;
        ADDR_DAC:     rdata_d = {12'h0, dac_a[PCT_W+11 -: 20]};
        default:      rdata_d = 32'h0;
      endcase
    end
  end

  // registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_peak_code_q   <= RUN_CODE_RST;
      hold_peak_code_q  <= HOLD_CODE_RST;
      hold_delay_code_q <= HOLD_DLY_RST;
      hold_q            <= 1'b0;
      hcnt_q            <= 32'h0;
      step_pin_q        <= 1'b0;
      ocflag_q          <= 4'h0;
      ovflag_q          <= 1'b0;
      irqmask_q         <= 4'h0;
      for (int i = 0; i < 4; i++) ocglit_q[i] <= 4'h0;
      aw_q              <= 1'b0;
      ar_q              <= 1'b0;
      aaddr_q           <= 8'h00;
      hrdata            <= 32'h0;
      dac_a             <= '0;
      dac_b             <= '0;
      bridge_en         <= 1'b0;
      stall_clr         <= 1'b0;
      irq               <= 1'b0;
      error_pin_low_active_oe <= 1'b0;
    end else if (clk_en) begin
      run_peak_code_q   <= run_peak_code_d;
      hold_peak_code_q  <= hold_peak_code_d;
      hold_delay_code_q <= hold_delay_code_d;
      hold_q            <= hold_d;
      hcnt_q            <= hcnt_d;
      step_pin_q        <= step_pin;
      ocflag_q          <= ocflag_d;
      ovflag_q          <= ovflag_d;
      irqmask_q         <= irqmask_d;
      for (int i = 0; i < 4; i++) ocglit_q[i] <= ocglit_d[i];
      aw_q              <= aw_d;
      ar_q              <= ar_d;
      aaddr_q           <= aaddr_d;
      hrdata            <= rdata_d;
      dac_a             <= dac_a_d;
      dac_b             <= dac_b_d;
      bridge_en         <= br_d;
      stall_clr         <= stall_clr_d;
      irq               <= irq_d;
      error_pin_low_active_oe <= flt_d;
    end
  end

  // open-drain pin only ever drives low; zero-wait slave, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      error_pin_low_active_o <= 1'b0;
      hreadyout              <= 1'b1;
      hresp                  <= 1'b0;
    end else begin
      error_pin_low_active_o <= 1'b0;
      hreadyout              <= 1'b1;
      hresp                  <= 1'b0;
    end
  end

endmodule

// ==== tb/schf_core_checker.sv ====
// Purpose: port-level checks on the current, hold and fault core
// Assumes: deglitch of 8 cycles, hold base far above 3 cycles
// Notes:   bound to every core instance
`timescale 1ns/1ns
module schf_core_checker (
  // clock, reset and bus
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       hsel,
  input wire logic       hreadyout,
  input wire logic       hresp,
  // sensing and outputs
  input wire logic [3:0] oc_raw,
  input wire logic       ov_raw,
  input wire logic       step_pin,
  input wire logic       bridge_en,
  input wire logic       stall_clr,
  input wire logic       irq,
  input wire logic       error_pin_low_active_o,
  input wire logic       error_pin_low_active_oe
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // consecutive cycles of any over-current level, saturating at nine
  logic [3:0] occnt_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      occnt_q <= 4'h0;
    end else if (oc_raw == 4'h0) begin
      occnt_q <= 4'h0;
    end else if (occnt_q != 4'h9) begin
      occnt_q <= occnt_q + 4'h1;
    end
  end
  // open drain: only ever pulls low, the pull-up does the rest
  AST_PIN_LOW: assert property (error_pin_low_active_o == 1'b0) else $error("pin driven high");
  AST_BUS_OK: assert property (hreadyout && !hresp) else $error("bus answer not okay");
  AST_OC_TRIP: assert property ($rose(occnt_q == 4'h9) |-> ##[1:3] (!bridge_en && error_pin_low_active_oe))
    else $error("over-current not latched");
  AST_OV_OFF: assert property ($rose(ov_raw) |-> ##[1:2] (!bridge_en && error_pin_low_active_oe))
    else $error("over-voltage ignored");
  // no write reached the bus, so nothing may have cleared a flag
  AST_OE_STICKY: assert property ((error_pin_low_active_oe && !hsel)[*4] |=> error_pin_low_active_oe)
    else $error("fault pin released alone");
  AST_IRQ_FAULT: assert property (irq |-> error_pin_low_active_oe || $past(error_pin_low_active_oe))
    else $error("irq without fault");
  AST_STALL_PULSE: assert property (stall_clr |=> !stall_clr) else $error("stall clear too long");
  AST_STEP_RESTART: assert property ($rose(step_pin) |=> !stall_clr[*3])
    else $error("hold began right after step");
endmodule
bind schf_core schf_core_checker chk (.*);

// ==== tb/schf_host.sv ====
// Purpose: host model, single-word bus master
// Assumes: one slave, its ready is the bus ready
// Notes:   waits on ready without a limit, the bench watchdog cuts hangs
`timescale 1ns/1ns
module schf_host (
  // bus
  input wire logic        hclk,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  output logic            hsel = 1'b0,
  output logic     [31:0] haddr = 32'h0,
  output logic     [1:0]  htrans = 2'h0,
  output logic            hwrite = 1'b0,
  output logic     [2:0]  hsize = 3'h2,
  output logic     [31:0] hwdata = 32'h0
);
  // address phase held until ready, then data phase until ready again
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
endmodule

// ==== tb/testbench.sv ====
// Purpose: self-checking bench for the current, hold and fault core
// Assumes: hold base shortened to 16 cycles
// Notes:   samples settle a cycle or more after each cause
`timescale 1ns/1ns
module testbench;
  import schf_pkg::*;
  logic        hclk = 0, hresetn = 0, clk_en = 1, step_pin = 0, ov_raw = 0;
  logic [3:0]  oc_raw = 4'h0;
  logic [7:0]  pct_a = 8'd50, pct_b = 8'd30;
  logic        hsel, hwrite, hready, hreadyout, hresp, bridge_en, stall_clr, irq;
  logic        error_pin_low_active_o, error_pin_low_active_oe;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [19:0] dac_a, dac_b;
  int          errors = 0, checks = 0, nstall = 0;
  assign hready = hreadyout;
  schf_core #(.HOLD_BASE(16)) uut (.*);
  schf_host host (.*);
  initial begin
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) if (stall_clr === 1'b1) nstall++;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rd);
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    host.xfer(1'b0, a, 32'h0, rd);
    chk(n, e, rd);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // expected phase current in percent-milliamps
  function automatic logic [31:0] amp(input logic [7:0] p, input logic [5:0] c);
    return 32'(p) * (32'(c) + 1) * 125;
  endfunction
  task automatic t_current();
    rdc("current_setting_reg", ADDR_CURRENT_SETTING_REG, 32'h9);
    rdc("ctrl", ADDR_CTRL, 32'h0);
    rdc("unmapped", 8'h08, 32'h0);
    for (int c = 0; c < 32; c += 31) begin
      wr(ADDR_CURRENT_SETTING_REG, 32'(c));
      cyc(3);
      chk("dac_a", amp(pct_a, 6'(c)), 32'(dac_a));
      chk("dac_b", amp(pct_b, 6'(c)), 32'(dac_b));
    end
    $display("test current done");
  endtask
  task automatic t_hold();
    wr(ADDR_CURRENT_SETTING_REG, 32'h031f);
    wr(ADDR_CTRL, 32'h10);
    cyc(10);
    chk("dac run", amp(pct_a, 6'h1f), 32'(dac_a));
    cyc(20);
    chk("dac hold", amp(pct_a, 6'h03), 32'(dac_a));
    rdc("hold bit", ADDR_FAULT, 32'h30);
    chk("stall", 32'h1, 32'(nstall));
    step_pin <= 1'b1;
    cyc(1);
    step_pin <= 1'b0;
    cyc(3);
    chk("dac pin", amp(pct_a, 6'h1f), 32'(dac_a));
    cyc(30);
    wr(ADDR_CTRL, 32'h11);
    cyc(3);
    chk("dac bit", amp(pct_a, 6'h1f), 32'(dac_a));
    wr(ADDR_CTRL, 32'h0);
    cyc(40);
    chk("dac off", amp(pct_a, 6'h1f), 32'(dac_a));
    $display("test hold done");
  endtask
  task automatic t_fault();
    wr(ADDR_IRQMASK, 32'h1);
    oc_raw <= 4'h1;
    cyc(5);
    oc_raw <= 4'h0;
    cyc(3);
    chk("glitch", 32'h1, 32'(bridge_en));
    for (int i = 0; i < 4; i++) begin
      oc_raw <= 4'(1 << i);
      cyc(12);
      oc_raw <= 4'h0;
      cyc(2);
      chk("bridge", 32'h0, 32'(bridge_en));
      chk("irq", 32'h1, 32'(irq));
      rdc("ocdet", ADDR_OCDET, 32'(1 << i));
      rdc("fault", ADDR_FAULT, 32'h1);
      wr(ADDR_OCDET, 32'(1 << i));
      cyc(3);
      chk("pin", 32'h0, 32'(error_pin_low_active_oe));
      rdc("fault", ADDR_FAULT, 32'h20);
    end
    ov_raw <= 1'b1;
    cyc(4);
    chk("bridge", 32'h0, 32'(bridge_en));
    chk("irq masked", 32'h0, 32'(irq));
    ov_raw <= 1'b0;
    cyc(4);
    chk("pin", 32'h1, 32'(error_pin_low_active_oe));
    rdc("fault", ADDR_FAULT, 32'h22);
    wr(ADDR_FAULT, 32'h2);
    cyc(3);
    chk("pin", 32'h0, 32'(error_pin_low_active_oe));
    $display("test fault done");
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // run needs well under two thousand cycles
  initial begin
    #200000;
    errors++;
    test_done();
  end
  initial begin
    cyc(5);
    hresetn <= 1'b1;
    t_current();
    t_hold();
    t_fault();
    test_done();
  end
endmodule
